// *** rtl/ivp_vector_ctrl.sv ***
/*
 * ivp_vector_ctrl: factor flags, masks, global enable and vector sequencer.
 * assumes the core pulses instr_done at each instruction boundary with the
 * address of the next instruction on next_pc, and obeys push and pc_load.
 */
`timescale 1ns/10ps
module ivp_vector_ctrl #(
   parameter int unsigned SEQ_CYCLES = ivp_pkg::SEQ_CYC
) (
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   input  wire ivp_pkg::ivp_bus_req_t             bus,
   output logic [ivp_pkg::DW-1:0]                 rdata,
   input  wire logic [ivp_pkg::NSRC-1:0]          src_event,
   input  wire logic                              instr_done,
   input  wire logic [ivp_pkg::PCW-1:0]           next_pc,
   output ivp_pkg::ivp_core_cmd_t                 core_cmd,
   output logic                                   cpu_req,
   output logic                                   busy,
   output logic                                   global_enabled_state,
   output logic                                   irq
);
   // ======================================================================
   // elaboration checks
   initial begin
      if (SEQ_CYCLES < 3)
         $error("ivp_vector_ctrl: SEQ_CYCLES below 3");
   end

   localparam int unsigned LAST = SEQ_CYCLES - 2;

   // ======================================================================
   // state
   typedef struct packed {
      ivp_pkg::ivp_state_t             fsm;
      logic [ivp_pkg::NSRC-1:0]        flags;
      logic [ivp_pkg::NSRC-1:0]        mask;
      logic                            gie;
      logic [ivp_pkg::DW-1:0]          stat;
      logic [ivp_pkg::DW-1:0]          imsk;
      logic [ivp_pkg::IDXW-1:0]        vec_idx;
      logic [ivp_pkg::DW-1:0]          rdata;
      ivp_pkg::ivp_core_cmd_t          cmd;
      logic                            cpu_req;
      logic                            busy;
      logic                            irq;
   } ivp_st_t;

   ivp_st_t st;
   ivp_st_t next_st;

   logic [ivp_pkg::NSRC-1:0]  pend;
   logic                      pend_any;
   logic [ivp_pkg::IDXW-1:0]  pend_idx;
   logic                      accept;
   logic                      seq_run;
   logic                      seq_done;

   // ======================================================================
   // arbitration
   assign pend = st.flags & st.mask;

   ivp_prio #(
      .N  (ivp_pkg::NSRC),
      .IW (ivp_pkg::IDXW)
   ) u_prio (
      .req (pend),
      .any (pend_any),
      .idx (pend_idx)
   );

   // boundary sampling; ignored while a sequence runs
   assign accept = instr_done && pend_any && st.gie
                   && (st.fsm == ivp_pkg::ST_IDLE);

   ivp_seq_cnt #(
      .LAST (LAST)
   ) u_seq (
      .clk     (clk),
      .rst_n   (rst_n),
      .start   (accept),
      .running (seq_run),
      .done    (seq_done)
   );

   // ======================================================================
   // vector of a source index
   function automatic logic [ivp_pkg::PCW-1:0] vec_of(
      input logic [ivp_pkg::IDXW-1:0] i
   );
      logic [7:0] step;
      step = ivp_pkg::VEC_BASE_STEP + {4'h0, i, 1'b0};
      return {ivp_pkg::VEC_PAGE, step};
   endfunction

   // ======================================================================
   // next state
   always_comb
   begin
      logic [ivp_pkg::NSRC-1:0] clr;
      logic [ivp_pkg::DW-1:0]   ev;
      logic [ivp_pkg::DW-1:0]   w1c;
      clr = '0;
      ev  = '0;
      w1c = '0;
      next_st = st;
      next_st.cmd.push    = 1'b0;
      next_st.cmd.pc_load = 1'b0;
      next_st.rdata       = ivp_pkg::NIB_RST;

      // ------------------------------------------------------------------
      // reads; flag reads clear the whole address
      if (bus.rd)
      begin
         case (bus.addr)
            ivp_pkg::REG_FLAG_LO:
            begin
               next_st.rdata = st.flags[3:0];
               clr[3:0] = 4'hF;
            end
            ivp_pkg::REG_FLAG_HI:
            begin
               next_st.rdata = {2'h0, st.flags[5:4]};
               clr[5:4] = 2'h3;
            end
            ivp_pkg::REG_MASK_LO: next_st.rdata = st.mask[3:0];
            ivp_pkg::REG_MASK_HI: next_st.rdata = {2'h0, st.mask[5:4]};
            ivp_pkg::REG_GEN:     next_st.rdata = {3'h0, st.gie};
            ivp_pkg::REG_STAT:    next_st.rdata = st.stat;
            ivp_pkg::REG_IMSK:    next_st.rdata = st.imsk;
            ivp_pkg::REG_VEC:     next_st.rdata = {st.busy, st.vec_idx};
            default:              next_st.rdata = ivp_pkg::NIB_RST;
         endcase
         // misuse is flagged, not blocked
         if ((bus.addr == ivp_pkg::REG_FLAG_LO || bus.addr == ivp_pkg::REG_FLAG_HI)
             && st.gie)
            ev[ivp_pkg::ST_BADRD] = 1'b1;
      end

      // ------------------------------------------------------------------
      // writes
      if (bus.wr)
      begin
         case (bus.addr)
            ivp_pkg::REG_MASK_LO:
            begin
               next_st.mask[3:0] = bus.wdata;
               ev[ivp_pkg::ST_BADWR] = st.gie;
            end
            ivp_pkg::REG_MASK_HI:
            begin
               next_st.mask[5:4] = bus.wdata[1:0];
               ev[ivp_pkg::ST_BADWR] = st.gie;
            end
            // re-enable with a live flag retriggers on next boundary
            ivp_pkg::REG_GEN:  next_st.gie  = bus.wdata[0];
            ivp_pkg::REG_STAT: w1c          = bus.wdata;
            ivp_pkg::REG_IMSK: next_st.imsk = bus.wdata;
            default: ;
         endcase
      end

      // ------------------------------------------------------------------
      // flags: a new event beats a same-cycle read clear
      next_st.flags = (st.flags & ~clr) | src_event;

      // ------------------------------------------------------------------
      // sequencer
      case (st.fsm)
         ivp_pkg::ST_IDLE:
         begin
            if (accept)
            begin
               next_st.fsm           = ivp_pkg::ST_SAVE;
               next_st.vec_idx       = pend_idx;
               next_st.cmd.push      = 1'b1;
               next_st.cmd.push_addr = next_pc;
               next_st.gie           = 1'b0;
               next_st.busy          = 1'b1;
               ev[ivp_pkg::ST_ACCEPT] = 1'b1;
            end
         end
         ivp_pkg::ST_SAVE:
         begin
            // vector index frozen here, so no late source can swap it
            if (seq_done)
            begin
               next_st.fsm          = ivp_pkg::ST_IDLE;
               next_st.cmd.pc_load  = 1'b1;
               next_st.cmd.pc_value = vec_of(st.vec_idx);
               next_st.busy         = 1'b0;
               ev[ivp_pkg::ST_LOADED] = 1'b1;
            end
            else if (!seq_run && !st.busy)
               next_st.fsm = ivp_pkg::ST_IDLE;
         end
         default:
            next_st.fsm = ivp_pkg::ST_IDLE;
      endcase

      // ------------------------------------------------------------------
      // busy also drops when load is issued
      if (st.cmd.pc_load)
         next_st.busy = 1'b0;

      // ------------------------------------------------------------------
      // status: set beats write-one-to-clear
      next_st.stat = (st.stat & ~w1c) | ev;

      // ------------------------------------------------------------------
      // registered outputs
      next_st.cpu_req = |(next_st.flags & next_st.mask) && next_st.gie;
      next_st.irq     = |(next_st.stat & next_st.imsk);
   end

   // ======================================================================
   // registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st                  <= '0;
         st.fsm              <= ivp_pkg::ST_IDLE;
         st.flags            <= ivp_pkg::FLAG_RST;
         st.mask             <= ivp_pkg::MASK_RST;
         st.cmd.push_addr    <= ivp_pkg::PC_RST;
         st.cmd.pc_value     <= ivp_pkg::PC_RST;
      end
      else
         st <= next_st;
   end

   // ======================================================================
   // outputs
   assign rdata                = st.rdata;
   assign core_cmd             = st.cmd;
   assign cpu_req              = st.cpu_req;
   assign busy                 = st.busy;
   assign global_enabled_state = st.gie;
   assign irq                  = st.irq;
endmodule // ivp_vector_ctrl

// *** rtl/ivp_pkg.sv ***
/*
 * ivp_pkg: constants and carrier types of the interrupt vectoring block.
 * assumes a 4-bit register port and a 12-bit program counter on the core side.
 */
package ivp_pkg;
   // ======================================================================
   // widths and sources
   localparam int unsigned NSRC   = 6;
   localparam int unsigned DW     = 4;
   localparam int unsigned AW     = 4;
   localparam int unsigned PCW    = 12;
   localparam int unsigned IDXW   = 3;
   localparam int unsigned SEQ_CYC = 12;
   // source index, low priority first
   localparam logic [IDXW-1:0] SRC_CLK_TIMER = 3'h0;
   localparam logic [IDXW-1:0] SRC_STOPWATCH = 3'h1;
   localparam logic [IDXW-1:0] SRC_IN_GROUP0 = 3'h2;
   localparam logic [IDXW-1:0] SRC_IN_GROUP1 = 3'h3;
   localparam logic [IDXW-1:0] SRC_SERIAL    = 3'h4;
   localparam logic [IDXW-1:0] SRC_PROG_TMR  = 3'h5;
   // ======================================================================
   // vector layout
   localparam logic [3:0] VEC_PAGE      = 4'h1;
   localparam logic [7:0] VEC_BASE_STEP = 8'h02;
   // ======================================================================
   // register offsets
   localparam logic [AW-1:0] REG_FLAG_LO = 4'h0;
   localparam logic [AW-1:0] REG_FLAG_HI = 4'h1;
   localparam logic [AW-1:0] REG_MASK_LO = 4'h2;
   localparam logic [AW-1:0] REG_MASK_HI = 4'h3;
   localparam logic [AW-1:0] REG_GEN     = 4'h4;
   localparam logic [AW-1:0] REG_STAT    = 4'h5;
   localparam logic [AW-1:0] REG_IMSK    = 4'h6;
   localparam logic [AW-1:0] REG_VEC     = 4'h7;
   // status bits
   localparam int unsigned ST_ACCEPT = 0;
   localparam int unsigned ST_LOADED = 1;
   localparam int unsigned ST_BADRD  = 2;
   localparam int unsigned ST_BADWR  = 3;
   // reset values
   localparam logic [NSRC-1:0] FLAG_RST = 6'h00;
   localparam logic [NSRC-1:0] MASK_RST = 6'h00;
   localparam logic [DW-1:0]   NIB_RST  = 4'h0;
   localparam logic [PCW-1:0]  PC_RST   = 12'h000;
   // ======================================================================
   // carriers
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic          wr;
      logic          rd;
   } ivp_bus_req_t;
   typedef struct packed {
      logic           push;
      logic [PCW-1:0] push_addr;
      logic           pc_load;
      logic [PCW-1:0] pc_value;
   } ivp_core_cmd_t;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_SAVE = 1'b1
   } ivp_state_t;
endpackage

// *** rtl/ivp_prio.sv ***
/*
 * ivp_prio: fixed priority pick, highest index wins.
 * assumes a combinational consumer that samples the result on its own clock.
 */
`timescale 1ns/10ps
module ivp_prio #(
   parameter int unsigned N  = 6,
   parameter int unsigned IW = 3
) (
   input  wire logic [N-1:0]  req,
   output logic               any,
   output logic [IW-1:0]      idx
);
   // ======================================================================
   // checks
   initial begin
      if (N < 1 || N > (1 << IW))
         $error("ivp_prio: N does not fit IW");
   end
   // ======================================================================
   // pick
   always_comb
   begin
      any = 1'b0;
      idx = '0;
      // scan upward so the last hit, the highest, stays
      for (int i = 0; i < N; i++)
      begin
         if (req[i])
         begin
            any = 1'b1;
            idx = IW'(i);
         end
      end
   end
endmodule // ivp_prio

// *** rtl/ivp_seq_cnt.sv ***
/*
 * ivp_seq_cnt: one-shot cycle counter for the save-and-load sequence.
 * assumes start is a one-cycle pulse, never given while running.
 */
`timescale 1ns/10ps
module ivp_seq_cnt #(
   parameter int unsigned LAST = 10
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   output logic      running,
   output logic      done
);
   localparam int unsigned CW = (LAST < 2) ? 1 : $clog2(LAST + 1);
   typedef struct packed {
      logic          run;
      logic [CW-1:0] cnt;
   } ivp_cnt_st_t;
   ivp_cnt_st_t st;
   ivp_cnt_st_t next_st;
   // ======================================================================
   // count
   assign running = st.run;
   assign done    = st.run && (st.cnt == CW'(LAST));
   always_comb
   begin
      next_st = st;
      if (start)
      begin
         next_st.run = 1'b1;
         next_st.cnt = '0;
      end
      else if (st.run)
      begin
         if (st.cnt == CW'(LAST))
            next_st.run = 1'b0;
         else
            next_st.cnt = st.cnt + CW'(1);
      end
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end
endmodule // ivp_seq_cnt

// *** sim/ivp_core_model.sv ***
/*
 * ivp_core_model: core side of the vectoring block, issues boundaries and obeys commands.
 * assumes push and pc_load are one-cycle pulses from the block under test.
 */
`timescale 1ns/10ps
module ivp_core_model (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire ivp_pkg::ivp_core_cmd_t core_cmd,
   output logic                        instr_done,
   output logic [ivp_pkg::PCW-1:0]     next_pc,
   output logic [7:0]                  seq_len
);
   // ======================================================================
   // boundary every third cycle, stalled through the save sequence
   logic [1:0] div;
   logic       stall;
   logic [7:0] cnt;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         div        <= 2'h0;
         stall      <= 1'b0;
         cnt        <= 8'h00;
         seq_len    <= 8'h00;
         instr_done <= 1'b0;
         next_pc    <= 12'h040;
      end
      else
      begin
         instr_done <= 1'b0;
         if (core_cmd.push)
         begin
            // no instruction runs while the return address is saved
            stall <= 1'b1;
            cnt   <= 8'h00;
         end
         else if (core_cmd.pc_load)
         begin
            stall   <= 1'b0;
            seq_len <= cnt + 8'h01;
            next_pc <= core_cmd.pc_value + 12'h001;
         end
         else if (stall)
            cnt <= cnt + 8'h01;
         else if (div == 2'h2)
         begin
            div        <= 2'h0;
            instr_done <= 1'b1;
            next_pc    <= next_pc + 12'h001;
         end
         else
            div <= div + 2'h1;
      end
   end
endmodule // ivp_core_model

// *** sim/ivp_vector_ctrl_assertions.sv ***
/*
 * ivp_vector_ctrl_chk: port checks of the vectoring block.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module ivp_vector_ctrl_chk #(
   parameter int unsigned SEQ_CYCLES = ivp_pkg::SEQ_CYC
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire ivp_pkg::ivp_bus_req_t    bus,
   input  wire logic [ivp_pkg::DW-1:0]   rdata,
   input  wire logic [ivp_pkg::NSRC-1:0] src_event,
   input  wire logic                     instr_done,
   input  wire logic [ivp_pkg::PCW-1:0]  next_pc,
   input  wire ivp_pkg::ivp_core_cmd_t   core_cmd,
   input  wire logic                     cpu_req,
   input  wire logic                     busy,
   input  wire logic                     global_enabled_state,
   input  wire logic                     irq
);
   localparam int LD = SEQ_CYCLES - 1;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ======================================================================
   // sequence, read data and reset
   property p_push; core_cmd.push |-> $past(instr_done) && core_cmd.push_addr == $past(next_pc);
   endproperty
   a_push: assert property (p_push) else $error("push without boundary");
   property p_len; core_cmd.push |-> ##LD core_cmd.pc_load; endproperty
   a_len: assert property (p_len) else $error("vector load late or early");
   property p_vec; core_cmd.pc_load |-> core_cmd.pc_value[11:8] == 4'h1 &&
      !core_cmd.pc_value[0] && core_cmd.pc_value[7:0] inside {[8'h02:8'h0C]}; endproperty
   a_vec: assert property (p_vec) else $error("vector outside page one");
   property p_dis; core_cmd.push |-> !global_enabled_state && !cpu_req; endproperty
   a_dis: assert property (p_dis) else $error("enable kept on accept");
   property p_req; cpu_req |-> global_enabled_state; endproperty
   a_req: assert property (p_req) else $error("request while disabled");
   property p_hold; busy && instr_done |=> !core_cmd.push; endproperty
   a_hold: assert property (p_hold) else $error("accept during sequence");
   property p_once; core_cmd.push |=> !core_cmd.push [*8]; endproperty
   a_once: assert property (p_once) else $error("push repeated");
   property p_rd; rdata != 4'h0 |-> $past(bus.rd); endproperty
   a_rd: assert property (p_rd) else $error("read data without read");
   property p_rst; $rose(rst_n) |-> !cpu_req && !irq && !global_enabled_state && !busy;
   endproperty
   a_rst: assert property (p_rst) else $error("state not cleared by reset");
endmodule // ivp_vector_ctrl_chk
bind ivp_vector_ctrl ivp_vector_ctrl_chk #(.SEQ_CYCLES(SEQ_CYCLES)) u_chk (.clk(clk),
   .rst_n(rst_n), .bus(bus), .rdata(rdata), .src_event(src_event), .instr_done(instr_done),
   .next_pc(next_pc), .core_cmd(core_cmd), .cpu_req(cpu_req), .busy(busy),
   .global_enabled_state(global_enabled_state), .irq(irq));

// *** sim/tb_top.sv ***
/*
 * tb_top: register-port sequences against the vectoring block and a core model.
 * assumes the default twelve-cycle sequence length.
 */
`timescale 1ns/10ps
module tb_top;
   logic                  clk;
   logic                  rst_n;
   ivp_pkg::ivp_bus_req_t bus;
   logic [3:0]            rdata;
   logic [5:0]            src_event;
   logic                  instr_done;
   logic [11:0]           next_pc;
   ivp_pkg::ivp_core_cmd_t core_cmd;
   logic                  cpu_req;
   logic                  busy;
   logic                  gie;
   logic                  irq;
   logic [7:0]            seq_len;
   logic [5:0]            e;
   int                    fail_count;
   int                    n_compared;
   ivp_vector_ctrl u_ivp_vector_ctrl (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .src_event(src_event), .instr_done(instr_done), .next_pc(next_pc),
      .core_cmd(core_cmd), .cpu_req(cpu_req), .busy(busy),
      .global_enabled_state(gie), .irq(irq));
   ivp_core_model u_ivp_core_model (.clk(clk), .rst_n(rst_n), .core_cmd(core_cmd),
      .instr_done(instr_done), .next_pc(next_pc), .seq_len(seq_len));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ======================================================================
   // tasks
   task automatic conclude();
      if (fail_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [3:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [3:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, exp});
   endtask
   task automatic ev(input logic [5:0] v);
      @(posedge clk);
      src_event <= v;
      @(posedge clk);
      src_event <= 6'h00;
   endtask
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   // wait for the vector load, bounded
   task automatic wait_load();
      int k;
      for (k = 0; k < 100 && core_cmd.pc_load !== 1'b1; k++)
      begin
         @(posedge clk);
         #1;
      end
      if (core_cmd.pc_load !== 1'b1)
      begin
         $display("mismatch at %0t: no vector load", $time);
         fail_count++;
         conclude();
      end
   endtask
   // ======================================================================
   // sequences
   initial
   begin
      fail_count = 0;
      n_compared = 0;
      bus = '0;
      src_event = 6'h00;
      rst_n = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(ivp_pkg::REG_FLAG_LO, 4'h0);
      rd(ivp_pkg::REG_MASK_LO, 4'h0);
      ev(6'h01);
      rd(ivp_pkg::REG_FLAG_LO, 4'h1);
      rd(ivp_pkg::REG_FLAG_LO, 4'h0);
      wr(ivp_pkg::REG_MASK_LO, 4'hF);
      wr(ivp_pkg::REG_MASK_HI, 4'h3);
      wr(ivp_pkg::REG_IMSK, 4'h1);
      // every source at once, highest must win
      ev(6'h3F);
      wr(ivp_pkg::REG_GEN, 4'h1);
      wait_load();
      chk(core_cmd.pc_value, 12'h10C);
      chk({11'h000, gie}, 12'h000);
      // core model takes the load one edge later
      @(posedge clk);
      #1;
      chk({4'h0, seq_len}, 12'h00B);
      settle();
      chk({11'h000, irq}, 12'h001);
      rd(ivp_pkg::REG_STAT, 4'h3);
      rd(ivp_pkg::REG_VEC, 4'h5);
      wr(ivp_pkg::REG_IMSK, 4'h0);
      settle();
      chk({11'h000, irq}, 12'h000);
      wr(ivp_pkg::REG_IMSK, 4'h1);
      wr(ivp_pkg::REG_STAT, 4'hF);
      settle();
      chk({11'h000, irq}, 12'h000);
      // flags left set retrigger on enable
      wr(ivp_pkg::REG_GEN, 4'h1);
      wait_load();
      chk(core_cmd.pc_value, 12'h10C);
      rd(ivp_pkg::REG_FLAG_LO, 4'hF);
      rd(ivp_pkg::REG_FLAG_HI, 4'h3);
      for (int i = 0; i < 6; i++)
      begin
         e = 6'(6'h01 << i);
         ev(e);
         wr(ivp_pkg::REG_GEN, 4'h1);
         wait_load();
         chk(core_cmd.pc_value, {4'h1, 8'h02 + 8'(2 * i)});
         rd(ivp_pkg::REG_FLAG_LO, e[3:0]);
         rd(ivp_pkg::REG_FLAG_HI, {2'b00, e[5:4]});
      end
      // masked source sets its flag but raises nothing
      wr(ivp_pkg::REG_MASK_LO, 4'h0);
      wr(ivp_pkg::REG_MASK_HI, 4'h0);
      ev(6'h01);
      wr(ivp_pkg::REG_GEN, 4'h1);
      repeat (20) @(posedge clk);
      #1;
      chk({10'h000, cpu_req, gie}, 12'h001);
      wr(ivp_pkg::REG_GEN, 4'h0);
      rd(ivp_pkg::REG_FLAG_LO, 4'h1);
      rd(4'h8, 4'h0);
      conclude();
   end
endmodule // tb_top
